// ===== design/usb_buffer_descriptor_engine.sv
`include "usb_bd_params.svh"
`timescale 1ns/1ps
`default_nettype none
module usb_buffer_descriptor_engine
  import usb_bd_pkg::*;
#(
  parameter int FIFO_DEPTH = `FIFO_DEPTH_DEF
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  table_base_pointer,
  input  wire logic [1:0]  usb_config_one,
  input  wire logic        host_mode,
  input  wire logic [7:0]  token_command,
  input  wire logic [7:0]  top_int_enable,
  input  wire logic [7:0]  error_int_enable,
  input  wire logic        top_flag_wr,
  input  wire logic [7:0]  top_flag_wr_data,
  input  wire logic        err_flag_wr,
  input  wire logic [7:0]  err_flag_wr_data,
  input  wire logic        stall_flag_wr,
  input  wire logic [15:0] stall_flag_wr_data,
  input  wire logic        tok_valid,
  output logic             tok_ready,
  input  wire logic [3:0]  tok_endpoint,
  input  wire logic        tok_is_in,
  input  wire logic        tok_odd,
  input  wire logic [3:0]  tok_pid,
  input  wire logic        tok_data_toggle,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_has_byte,
  input  wire logic        rx_last,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [7:0]       tx_data,
  output logic             tx_has_byte,
  output logic             tx_last,
  output logic             tx_toggle,
  output logic             hs_valid,
  output logic [1:0]       hs_code,
  output logic             mem_req,
  output logic             mem_we,
  output logic [1:0]       mem_be,
  output logic [15:0]      mem_addr,
  output logic [15:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata,
  output logic [7:0]       top_int_flags,
  output logic [7:0]       error_int_flags,
  output logic [15:0]      endpoint_stall_flag,
  output logic [7:0]       last_transfer_status,
  output logic             irq
);
  typedef struct packed {
    state_t     st;
    logic [3:0] ep;
    logic [3:0] ep_tag;
    logic       is_in;
    logic       odd;
    logic [3:0] pid;
    logic       rx_tog;
    logic [5:0] slot;
    logic [15:0] stat;
    logic [15:0] badr;
    logic [9:0] cnt;
    logic       drop;
    logic       req;
    logic       we;
    logic [1:0] be;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic       push;
    fifo_word_t push_data;
    fifo_word_t hold;
    logic       hs_valid;
    hs_t        hs_code;
    logic [7:0] top_flags;
    logic [7:0] err_flags;
    logic [15:0] ep_stall;
    logic [7:0] xfer_status;
  } eng_t;

  eng_t        e_reg;
  eng_t        e_next;
  logic [5:0]  map_slot;
  logic [3:0]  map_ep;
  logic [7:0]  top_set;
  logic [7:0]  err_set;
  logic [15:0] stall_set;
  logic [16:0] buf_sum;
  logic        buf_wrap;
  logic [9:0]  byte_cnt;
  fifo_word_t  head;

  fifo_link_if #(.WIDTH($bits(fifo_word_t))) link ();

  byte_fifo #(
    .WIDTH ($bits(fifo_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk     (clk),
    .sys_rst (sys_rst),
    .lnk     (link.buffer)
  );

  assign map_ep = host_mode ? 4'h0 : tok_endpoint;

  bd_slot_map u_map (
    .ep    (map_ep),
    .is_in (tok_is_in),
    .odd   (tok_odd),
    .mode  (pp_mode_t'(usb_config_one)),
    .slot  (map_slot)
  );

  // One FIFO serves both directions: the engine fills it on IN, the link on OUT
  assign head           = link.out_data;
  assign link.in_valid  = e_reg.is_in ? e_reg.push : rx_valid;
  assign link.in_data   = e_reg.is_in ? e_reg.push_data : {rx_last, rx_has_byte, rx_data};
  assign link.out_ready = e_reg.is_in ? tx_ready : (e_reg.st == ST_RX_POP);
  assign rx_ready       = !e_reg.is_in && link.in_ready;
  assign tx_valid       = e_reg.is_in && link.out_valid;
  assign tx_data        = head.data;
  assign tx_has_byte    = head.has_byte;
  assign tx_last        = head.last;
  assign tok_ready      = (e_reg.st == ST_IDLE);

  assign byte_cnt = e_reg.stat[`BD_BC_MSB:0];
  assign buf_sum  = {1'b0, e_reg.badr} + {7'h00, e_reg.cnt};
  assign buf_wrap = buf_sum[16];

  always_comb begin
    e_next            = e_reg;
    e_next.hs_valid   = 1'b0;
    top_set           = '0;
    err_set           = '0;
    stall_set         = '0;
    if (e_reg.push && link.in_ready) begin
      e_next.push = 1'b0;
    end
    if (e_reg.req && mem_ack) begin
      e_next.req = 1'b0;
    end
    case (e_reg.st)
      ST_IDLE: begin
        if (tok_valid) begin
          e_next.ep     = map_ep;
          e_next.ep_tag = (host_mode && tok_is_in) ? token_command[3:0] : tok_endpoint;
          e_next.is_in  = tok_is_in;
          e_next.odd    = tok_odd;
          e_next.pid    = tok_pid;
          e_next.rx_tog = tok_data_toggle;
          e_next.slot   = map_slot;
          e_next.req    = 1'b1;
          e_next.we     = 1'b0;
          e_next.be     = `LANE_WORD;
          e_next.addr   = {table_base_pointer[`BD_BASE_MSB:`BD_BASE_LSB], 1'b0,
                           map_slot, `BD_STAT_SEL};
          e_next.st     = ST_RD_STAT;
        end
      end
      ST_RD_STAT: begin
        if (mem_ack) begin
          e_next.stat = mem_rdata;
          if (!mem_rdata[`BD_OWNER_BIT]) begin
            e_next.hs_valid = 1'b1;
            e_next.hs_code  = HS_NAK;
            e_next.st       = ST_IDLE;
          end else if (mem_rdata[`BD_BUFFER_STALL_BIT]) begin
            e_next.hs_valid      = 1'b1;
            e_next.hs_code       = HS_STALL;
            stall_set[e_reg.ep]  = 1'b1;
            top_set[`TOP_STALL_BIT] = 1'b1;
            e_next.st            = ST_IDLE;
          end else begin
            e_next.req  = 1'b1;
            e_next.addr = {e_reg.addr[15:2], `BD_ADR_SEL};
            e_next.st   = ST_RD_ADR;
          end
        end
      end
      ST_RD_ADR: begin
        if (mem_ack) begin
          e_next.badr = mem_rdata;
          e_next.cnt  = '0;
          e_next.drop = !e_reg.is_in && e_reg.stat[`BD_TOGGLE_SYNC_ENABLE_BIT]
                        && (e_reg.rx_tog != e_reg.stat[`BD_DTS_BIT]);
          err_set[`ERR_TOG_BIT] = e_next.drop;
          e_next.st   = e_reg.is_in ? ST_TX_RD : ST_RX_POP;
        end
      end
      ST_TX_RD: begin
        if (!e_reg.push && !e_reg.req) begin
          if (byte_cnt == '0 || buf_wrap) begin
            err_set[`ERR_DMA_BIT] = buf_wrap;
            e_next.push      = 1'b1;
            e_next.push_data = '{last: 1'b1, has_byte: 1'b0, data: 8'h00};
            e_next.st        = ST_TX_WAIT;
          end else begin
            e_next.req  = 1'b1;
            e_next.we   = 1'b0;
            e_next.addr = buf_sum[15:0];
            e_next.be   = buf_sum[0] ? `LANE_HI : `LANE_LO;
            e_next.st   = ST_TX_ACK;
          end
        end
      end
      ST_TX_ACK: begin
        if (mem_ack) begin
          e_next.push           = 1'b1;
          e_next.push_data.data = e_reg.addr[0] ? mem_rdata[15:8] : mem_rdata[7:0];
          e_next.push_data.has_byte = 1'b1;
          e_next.push_data.last = (e_reg.cnt + 10'h001 == byte_cnt);
          e_next.cnt            = e_reg.cnt + 10'h001;
          e_next.st             = e_next.push_data.last ? ST_TX_WAIT : ST_TX_RD;
        end
      end
      ST_TX_WAIT: begin
        if (!e_reg.push && !link.out_valid) begin
          e_next.st = ST_WR_STAT;
        end
      end
      ST_RX_POP: begin
        if (link.out_valid) begin
          e_next.hold = head;
          if (head.has_byte && !e_reg.drop && e_reg.cnt < byte_cnt && !buf_wrap) begin
            e_next.req   = 1'b1;
            e_next.we    = 1'b1;
            e_next.addr  = buf_sum[15:0];
            e_next.be    = buf_sum[0] ? `LANE_HI : `LANE_LO;
            e_next.wdata = {head.data, head.data};
            e_next.st    = ST_RX_WR;
          end else begin
            err_set[`ERR_OVR_BIT] = head.has_byte && !e_reg.drop && e_reg.cnt >= byte_cnt;
            err_set[`ERR_DMA_BIT] = head.has_byte && !e_reg.drop && buf_wrap;
            e_next.st = head.last ? ST_RX_END : ST_RX_POP;
          end
        end
      end
      ST_RX_WR: begin
        if (mem_ack) begin
          e_next.cnt = e_reg.cnt + 10'h001;
          e_next.st  = e_reg.hold.last ? ST_RX_END : ST_RX_POP;
        end
      end
      ST_RX_END: begin
        e_next.hs_valid = 1'b1;
        e_next.hs_code  = e_reg.drop ? HS_NONE : HS_ACK;
        e_next.st       = e_reg.drop ? ST_IDLE : ST_WR_STAT;
      end
      ST_WR_STAT: begin
        if (e_reg.req && mem_ack) begin
          e_next.st = ST_DONE;
        end else if (!e_reg.req) begin
          e_next.req   = 1'b1;
          e_next.we    = 1'b1;
          e_next.be    = `LANE_WORD;
          e_next.addr  = {table_base_pointer[`BD_BASE_MSB:`BD_BASE_LSB], 1'b0,
                          e_reg.slot, `BD_STAT_SEL};
          e_next.wdata = {1'b0, e_reg.stat[`BD_DTS_BIT], e_reg.pid, e_reg.cnt};
        end
      end
      ST_DONE: begin
        top_set[`TOP_TRN_BIT] = 1'b1;
        e_next.xfer_status    = {e_reg.ep_tag, e_reg.is_in, e_reg.odd, 2'b00};
        e_next.st             = ST_IDLE;
      end
      default: e_next.st = ST_IDLE;
    endcase
    // Set wins over a clear in the same cycle
    err_set = err_set | (e_reg.err_flags & ~(err_flag_wr ? err_flag_wr_data : 8'h00));
    e_next.err_flags = err_set;
    top_set[`TOP_ERR_BIT] = top_set[`TOP_ERR_BIT] | (|(e_reg.err_flags & error_int_enable));
    e_next.top_flags = top_set
                     | (e_reg.top_flags & ~(top_flag_wr ? top_flag_wr_data : 8'h00));
    e_next.ep_stall  = stall_set
                     | (e_reg.ep_stall & ~(stall_flag_wr ? stall_flag_wr_data : 16'h0000));
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      e_reg             <= '0;
      e_reg.st          <= ST_IDLE;
      e_reg.top_flags   <= `FLAGS_RST;
      e_reg.err_flags   <= `FLAGS_RST;
      e_reg.ep_stall    <= `STALL_RST;
      e_reg.xfer_status <= `XS_RST;
    end else begin
      e_reg <= e_next;
    end
  end

  assign mem_req              = e_reg.req;
  assign mem_we               = e_reg.we;
  assign mem_be               = e_reg.be;
  assign mem_addr             = e_reg.addr;
  assign mem_wdata            = e_reg.wdata;
  assign hs_valid             = e_reg.hs_valid;
  assign hs_code              = e_reg.hs_code;
  assign tx_toggle            = e_reg.stat[`BD_DTS_BIT];
  assign top_int_flags        = e_reg.top_flags;
  assign error_int_flags      = e_reg.err_flags;
  assign endpoint_stall_flag  = e_reg.ep_stall;
  assign last_transfer_status = e_reg.xfer_status;
  assign irq                  = |(e_reg.top_flags & top_int_enable);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence stat_written_s;
    e_reg.st == ST_WR_STAT && e_reg.req && mem_ack;
  endsequence

  table_base_addr_a: assert property ((e_reg.st == ST_RD_STAT && mem_req) |-> mem_addr[15:9] == table_base_pointer[7:1]) else $error("descriptor outside table");
  host_ep0_slot_a: assert property ((host_mode && usb_config_one == 2'b00 && tok_valid && tok_ready) |=> mem_addr[7:2] == {5'h00, $past(tok_is_in)}) else $error("host used non-ep0 slot");
  unowned_nak_a: assert property ((e_reg.st == ST_RD_STAT && mem_ack && !mem_rdata[15]) |=> hs_valid && hs_code == HS_NAK && tok_ready) else $error("unowned descriptor not refused");
  stall_flagged_a: assert property ((hs_valid && hs_code == HS_STALL) |-> endpoint_stall_flag[e_reg.ep] && !mem_req) else $error("stall without flag");
  status_word_a: assert property ((e_reg.st == ST_WR_STAT && mem_req) |-> !mem_wdata[15] && mem_wdata[9:0] == e_reg.cnt && mem_wdata[13:10] == e_reg.pid) else $error("bad status write");
  done_after_stat_a: assert property (stat_written_s |=> ##1 top_int_flags[3]) else $error("done flag missing");
  toggle_drop_a: assert property ((e_reg.drop && !e_reg.is_in && e_reg.st != ST_IDLE && e_reg.st != ST_RD_STAT) |-> !(mem_req && mem_we)) else $error("wrong toggle data stored");
  w1c_zero_a: assert property ((top_flag_wr && top_flag_wr_data == 8'h00) |=> ($past(top_int_flags) & ~top_int_flags) == 8'h00) else $error("zero write cleared a flag");
  err_summary_a: assert property ((|(error_int_flags & error_int_enable)) |=> top_int_flags[1]) else $error("error summary not set");
  irq_rise_a: assert property (($rose(top_int_flags[3]) && top_int_enable[3]) |-> irq) else $error("interrupt not raised");
  dma_limit_a: assert property ((e_reg.st == ST_RX_WR && mem_req) |-> mem_addr == buf_sum[15:0] && !buf_wrap) else $error("dma beyond 64K");
endmodule
`default_nettype wire

// ===== design/usb_bd_params.svh
`ifndef USB_BD_PARAMS_SVH
`define USB_BD_PARAMS_SVH

// Descriptor status word fields
`define BD_OWNER_BIT   15
`define BD_DTS_BIT     14
`define BD_PID_MSB     13
`define BD_PID_LSB     10
`define BD_TOGGLE_SYNC_ENABLE_BIT   11
`define BD_BUFFER_STALL_BIT  10
`define BD_BC_MSB      9

// Table base pointer bits that carry the 512-byte aligned table address
`define BD_BASE_MSB    7
`define BD_BASE_LSB    1

// Word select inside a four-byte descriptor
`define BD_STAT_SEL    2'b00
`define BD_ADR_SEL     2'b10

// Top level flag bits
`define TOP_ERR_BIT    1
`define TOP_TRN_BIT    3
`define TOP_STALL_BIT  5

// Error flag bits
`define ERR_TOG_BIT    0
`define ERR_OVR_BIT    1
`define ERR_DMA_BIT    2

// Byte lanes of the 16-bit memory port
`define LANE_LO        2'b01
`define LANE_HI        2'b10
`define LANE_WORD      2'b11

// Reset values
`define FLAGS_RST      8'h00
`define STALL_RST      16'h0000
`define XS_RST         8'h00

`define FIFO_DEPTH_DEF 4

`endif

// ===== design/usb_bd_pkg.sv
package usb_bd_pkg;

  typedef enum logic [1:0] {
    PP_NONE        = 2'b00,
    PP_EP0_OUT     = 2'b01,
    PP_ALL         = 2'b10,
    PP_ALL_BUT_EP0 = 2'b11
  } pp_mode_t;

  typedef enum logic [1:0] {
    HS_NONE  = 2'b00,
    HS_ACK   = 2'b01,
    HS_NAK   = 2'b10,
    HS_STALL = 2'b11
  } hs_t;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_RD_STAT = 4'b0001,
    ST_RD_ADR  = 4'b0010,
    ST_TX_RD   = 4'b0011,
    ST_TX_ACK  = 4'b0100,
    ST_TX_WAIT = 4'b0101,
    ST_RX_POP  = 4'b0110,
    ST_RX_WR   = 4'b0111,
    ST_RX_END  = 4'b1000,
    ST_WR_STAT = 4'b1001,
    ST_DONE    = 4'b1010
  } state_t;

  typedef struct packed {
    logic       last;
    logic       has_byte;
    logic [7:0] data;
  } fifo_word_t;

endpackage

// ===== design/fifo_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fifo_link_if #(parameter int WIDTH = 10);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;
  modport buffer (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user   (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

// ===== design/bd_slot_map.sv
`timescale 1ns/1ps
`default_nettype none
module bd_slot_map
  import usb_bd_pkg::*;
(
  input  wire logic [3:0] ep,
  input  wire logic       is_in,
  input  wire logic       odd,
  input  wire pp_mode_t   mode,
  output logic      [5:0] slot
);
  logic [6:0] n2;
  logic [6:0] n4;
  logic [6:0] s;

  always_comb begin
    n2 = {2'b00, ep, 1'b0};
    n4 = {1'b0, ep, 2'b00};
    case (mode)
      PP_NONE:        s = n2 + {6'h00, is_in};
      PP_EP0_OUT: begin
        if (ep == 4'h0) begin
          s = is_in ? 7'h02 : {6'h00, odd};
        end else begin
          s = n2 + 7'h01 + {6'h00, is_in};
        end
      end
      PP_ALL:         s = n4 + {5'h00, is_in, odd};
      PP_ALL_BUT_EP0: begin
        if (ep == 4'h0) begin
          s = {6'h00, is_in};
        end else begin
          s = n4 - 7'h02 + {5'h00, is_in, odd};
        end
      end
      default:        s = 7'h00;
    endcase
    slot = s[5:0];
  end
endmodule
`default_nettype wire

// ===== design/byte_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  input  wire logic     clk,
  input  wire logic     sys_rst,
  fifo_link_if.buffer   lnk
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_cfg
    $error("byte_fifo: DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } fifo_state_t;

  fifo_state_t f_reg;
  fifo_state_t f_next;
  logic        do_push;
  logic        do_pop;

  assign lnk.in_ready  = (f_reg.cnt != DEPTH[AW:0]);
  assign lnk.out_valid = (f_reg.cnt != '0);
  assign lnk.out_data  = f_reg.mem[f_reg.rp];

  always_comb begin
    f_next  = f_reg;
    do_push = lnk.in_valid && lnk.in_ready;
    do_pop  = lnk.out_valid && lnk.out_ready;
    if (do_push) begin
      f_next.mem[f_reg.wp] = lnk.in_data;
      f_next.wp            = f_reg.wp + 1'b1;
    end
    if (do_pop) begin
      f_next.rp = f_reg.rp + 1'b1;
    end
    f_next.cnt = f_reg.cnt + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
  end
endmodule
`default_nettype wire

// ===== tb/ram_model.sv
`timescale 1ns/1ps
`default_nettype none
module ram_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [1:0]  mem_be,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic             mem_ack,
  output logic [15:0]      mem_rdata
);
  logic [7:0]  mem [0:65535];
  logic [15:0] a;
  // Random answer delay; read data scrambled outside the ack cycle
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_ack <= 1'b0;
      mem_rdata <= 16'h0000;
    end else begin
      a = {mem_addr[15:1], 1'b0};
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack && $urandom_range(2) == 0) begin
        mem_ack <= 1'b1;
        mem_rdata <= {mem[a + 16'h0001], mem[a]};
        if (mem_we && mem_be[0]) begin
          mem[a] <= mem_wdata[7:0];
        end
        if (mem_we && mem_be[1]) begin
          mem[a + 16'h0001] <= mem_wdata[15:8];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/usb_buffer_descriptor_engine_bench.sv
`timescale 1ns/1ps
`default_nettype none
module usb_buffer_descriptor_engine_bench;
  import usb_bd_pkg::*;
  logic        clk = 0, sys_rst = 1, host_mode = 0, top_flag_wr = 0, err_flag_wr = 0;
  logic        stall_flag_wr = 0, tok_valid = 0, tok_is_in = 0, tok_odd = 0;
  logic        tok_data_toggle = 0, rx_valid = 0, rx_has_byte = 0, rx_last = 0, tx_ready = 0;
  logic [1:0]  usb_config_one = 0;
  logic [3:0]  tok_endpoint = 0, tok_pid = 0;
  logic [7:0]  table_base_pointer = 0, token_command = 0, top_int_enable = 0;
  logic [7:0]  error_int_enable = 0, top_flag_wr_data = 0, err_flag_wr_data = 0, rx_data = 0;
  logic [15:0] stall_flag_wr_data = 0;
  logic        tok_ready, rx_ready, tx_valid, tx_has_byte, tx_last, tx_toggle, hs_valid;
  logic        mem_req, mem_we, mem_ack, irq;
  logic [1:0]  hs_code, mem_be, hs_got;
  logic [7:0]  tx_data, top_int_flags, error_int_flags, last_transfer_status;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, endpoint_stall_flag;
  int          num_errors = 0, total_checks = 0, tn = 0;

  usb_buffer_descriptor_engine #(.FIFO_DEPTH(4)) i_usb_buffer_descriptor_engine (
    .clk, .sys_rst, .table_base_pointer, .usb_config_one, .host_mode, .token_command,
    .top_int_enable, .error_int_enable, .top_flag_wr, .top_flag_wr_data, .err_flag_wr,
    .err_flag_wr_data, .stall_flag_wr, .stall_flag_wr_data, .tok_valid, .tok_ready,
    .tok_endpoint, .tok_is_in, .tok_odd, .tok_pid, .tok_data_toggle, .rx_valid, .rx_ready,
    .rx_data, .rx_has_byte, .rx_last, .tx_valid, .tx_ready, .tx_data, .tx_has_byte,
    .tx_last, .tx_toggle, .hs_valid, .hs_code, .mem_req, .mem_we, .mem_be, .mem_addr,
    .mem_wdata, .mem_ack, .mem_rdata, .top_int_flags, .error_int_flags,
    .endpoint_stall_flag, .last_transfer_status, .irq);

  ram_model i_ram_model (.clk, .sys_rst, .mem_req, .mem_we, .mem_be, .mem_addr, .mem_wdata,
    .mem_ack, .mem_rdata);

  always #20 clk = ~clk;

  always @(posedge clk) begin
    if (hs_valid === 1'b1) begin
      hs_got <= hs_code;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Expected descriptor slot for each ping-pong mode
  function automatic logic [5:0] slot_of(input logic [1:0] m, input logic [3:0] ep,
                                         input logic in, input logic odd);
    case (m)
      2'h0: return {ep, in};
      2'h1: return (ep == 4'h0) ? (in ? 6'h02 : {5'h00, odd}) : {ep, in} + 6'h01;
      2'h2: return {ep, in, odd};
      default: return (ep == 4'h0) ? {5'h00, in} : {ep, 2'h0} - 6'h02 + 6'({in, odd});
    endcase
  endfunction

  // Clear pulses on error, top and stall flags in that order
  task automatic clr(input logic [7:0] v);
    @(posedge clk);
    #1 err_flag_wr = 1;
    err_flag_wr_data = v;
    @(posedge clk);
    #1 err_flag_wr = 0;
    top_flag_wr = 1;
    top_flag_wr_data = v;
    @(posedge clk);
    #1 top_flag_wr = 0;
    stall_flag_wr = 1;
    stall_flag_wr_data = {v, v};
    @(posedge clk);
    #1 stall_flag_wr = 0;
    @(posedge clk);
    #1;
  endtask

  // Kind: 0 normal, 1 stall, 2 not owned, 3 toggle mismatch
  task automatic xfer(input int kind, input logic [1:0] m, input logic [3:0] ep,
                      input logic in, input logic odd, input logic hst, input int n);
    logic [15:0] ta, bf, st, exp_st, save;
    logic [7:0]  dat [$];
    logic [7:0]  got [$];
    logic        toggle_select, en;
    int          i, k, beats, lasts;
    tn++;
    table_base_pointer = {2'h0, 5'($urandom_range(31)), 1'($urandom)};
    ta = {table_base_pointer[7:1], 9'h000} + {8'h00, slot_of(m, hst ? 4'h0 : ep, in, odd), 2'h0};
    bf = 16'h8000 + 16'($urandom_range(4095));
    toggle_select = 1'($urandom);
    en = (kind == 3) | 1'($urandom);
    st = {kind != 2, toggle_select, 2'h0, en, kind == 1 || kind == 2, 10'(n + (in ? 0 : $urandom_range(3)))};
    for (i = 0; i < n; i++) begin
      dat.push_back(8'($urandom));
      i_ram_model.mem[bf + 16'(i)] = in ? dat[i] : ~dat[i];
    end
    {i_ram_model.mem[ta + 16'h0001], i_ram_model.mem[ta]} = st;
    {i_ram_model.mem[ta + 16'h0003], i_ram_model.mem[ta + 16'h0002]} = bf;
    usb_config_one = m;
    host_mode = hst;
    tok_endpoint = ep;
    tok_is_in = in;
    tok_odd = odd;
    tok_pid = 4'($urandom);
    token_command = 8'($urandom);
    top_int_enable = {4'h0, 1'($urandom), 3'h0};
    tok_data_toggle = (kind == 3) ? ~toggle_select : (en ? toggle_select : 1'($urandom));
    hs_got = 2'hx;
    beats = (n == 0) ? 1 : n;
    @(posedge clk);
    #1 tok_valid = 1;
    @(posedge clk);
    #1 tok_valid = 0;
    i = 0;
    lasts = 0;
    for (k = 0; k < 4000 && !(k > 2 && tok_ready === 1'b1); k++) begin
      @(posedge clk);
      if (rx_valid && rx_ready === 1'b1) i++;
      if (tx_valid === 1'b1 && tx_ready && tx_has_byte === 1'b1) got.push_back(tx_data);
      if (tx_valid === 1'b1 && tx_ready && tx_last === 1'b1) lasts++;
      #1 tx_ready = 1'($urandom);
      rx_valid = !in && i < beats;
      rx_data = (i < n) ? dat[i] : 8'h00;
      rx_has_byte = n > 0;
      rx_last = i == beats - 1;
    end
    rx_valid = 0;
    tx_ready = 0;
    if (k == 4000) begin
      num_errors++;
      $display("ERROR %0t transfer hung", $time);
      give_verdict();
    end
    repeat (3) @(posedge clk);
    #1 exp_st = (kind == 0) ? {1'b0, toggle_select, tok_pid, 10'(n)} : st;
    check({i_ram_model.mem[ta + 16'h0001], i_ram_model.mem[ta]}, exp_st);
    if (kind != 0 || !in) check(16'(hs_got), 16'((kind == 0) ? 1 : (kind == 3) ? 0 : 4 - kind));
    if (kind == 0) begin
      if (in) check(16'(got.size()), 16'(n));
      if (in) check(16'(lasts), 16'h0001);
      check(16'(tx_toggle), 16'(toggle_select));
      for (i = 0; i < n; i++) check(in ? got[i] : i_ram_model.mem[bf + 16'(i)], dat[i]);
      check(top_int_flags[3], 16'h0001);
      check(irq, top_int_enable[3]);
      check(16'(last_transfer_status), 16'({hst && in ? token_command[3:0] : ep, in, odd, 2'b00}));
    end
    if (kind == 1) check(endpoint_stall_flag[ep], 16'h0001);
    if (kind == 3) check({error_int_flags[0], top_int_flags[1], top_int_flags[3]}, 16'h0006);
    save = {top_int_flags, error_int_flags};
    clr(8'h00);
    check({top_int_flags, error_int_flags}, save);
    clr(8'hff);
    check({top_int_flags, error_int_flags}, 16'h0000);
    check(endpoint_stall_flag, 16'h0000);
    $display("test %0d done", tn);
  endtask

  initial begin
    void'($urandom(32'h5a06_885a));
    error_int_enable = 8'($urandom) | 8'h01;
    repeat (10) @(posedge clk);
    #1 sys_rst = 0;
    for (int m = 0; m < 4; m++) begin
      for (int j = 0; j < 2; j++) begin
        xfer(0, 2'(m), j ? 4'hf : 4'h0, j[0], j[0], 1'b0, 3);
      end
    end
    for (int r = 0; r < 30; r++) begin
      xfer(0, 2'($urandom), 4'($urandom), 1'($urandom), 1'($urandom), $urandom_range(3) == 0,
           $urandom_range(8));
    end
    xfer(1, 2'h2, 4'h5, 1'b1, 1'b0, 1'b0, 4);
    xfer(2, 2'h0, 4'h3, 1'b1, 1'b1, 1'b0, 4);
    xfer(3, 2'h3, 4'h7, 1'b0, 1'b1, 1'b0, 3);
    give_verdict();
  end
endmodule
`default_nettype wire
